// file: verilog/pcs_core.sv
// Purpose: Program counter, circular return stack and indirect data addressing
// Assumes: One clock; core strobes are one-cycle pulses, at most one control per cycle
// Notes: Registers are reached over APB with zero wait states
//    Read data is captured in the setup phase and holds until the next setup phase
//    Control priority is return, call, interrupt, jump, low-byte write, fetch
//    Stack slots are not reset; a pop from an empty stack reads a wrapped slot
//    The indirect port sits at the same bank-relative location in every bank
//    Push and pop tallies below exist only to check the hidden pointer
// Operation
// - Counter is 13 bits; low byte accessible, upper five only loaded from latch.
// - Any reset clears the whole program counter.
// - Writing the low byte loads upper five bits from latch bits 4..0 together.
// - Call or jump takes counter bits 12..11 from latch bits 4..3.
// - Eight-entry, 13-bit return stack, hidden from memory, pointer not accessible.
// - Call or interrupt vectoring pushes the current counter.
// - Return, return with literal, return from interrupt pop into the counter.
// - Push and pop leave the high latch unchanged.
// - Stack wraps circularly; ninth push overwrites the first entry.
// - No overflow or underflow indication; wrapping is silent.
// - Indirect port has no storage; accesses go to the pointer's location.
// - Indirect read of the indirect port itself returns zero.
// - Indirect write to the indirect port itself changes no storage.
// - Effective address is bank page bit above the 8-bit pointer.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pcs_core (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic fetch_adv, // Instruction fetched, advance counter
   input wire logic pcl_wr, // Instruction writes the low byte
   input wire logic [7:0] pcl_wdata, // Low byte value from the core
   input wire logic call_instr, // Call executes
   input wire logic jump_instr, // Jump executes
   input wire logic [10:0] branch_target, // Target bits from the instruction
   input wire logic int_vector, // Interrupt branches to its vector
   input wire logic return_instr, // Any return kind executes
   input wire logic dacc_valid, // Core data access
   input wire logic dacc_we, // Core data access is a write
   input wire logic [8:0] dacc_addr, // Direct address incl. bank
   input wire logic [7:0] dacc_wdata, // Core write data
   output logic [7:0] dacc_rdata, // Read data to the core
   output logic [8:0] mem_addr, // Address to data memory
   output logic mem_we, // Write strobe to data memory
   output logic [7:0] mem_wdata, // Write data to data memory
   input wire logic [7:0] mem_rdata, // Read data from data memory
   output logic [12:0] pc // Program counter
);
   // Register decode shared by read and write
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      logic [2:0] s;
      s = pcs_pkg::SEL_NONE;
      if (a == pcs_pkg::OFS_PC_LOW) s = pcs_pkg::SEL_PC_LOW;
      if (a == pcs_pkg::OFS_HIGH_LATCH) s = pcs_pkg::SEL_HIGH_LATCH;
      if (a == pcs_pkg::OFS_POINTER) s = pcs_pkg::SEL_POINTER;
      if (a == pcs_pkg::OFS_BANK_PAGE) s = pcs_pkg::SEL_BANK_PAGE;
      if (a == pcs_pkg::OFS_PC_STATUS) s = pcs_pkg::SEL_PC_STATUS;
      return s;
   endfunction

   logic [12:0] pc_q, pc_d;
   logic [2:0] sp_q, sp_d;
   logic [12:0] stack_q [pcs_pkg::STK_DEPTH];
   logic [4:0] latch_q, latch_d;
   logic [7:0] pointer_q, pointer_d;
   logic bank_page_q, bank_page_d;
   logic [31:0] prdata_q, prdata_d;
   logic apb_wr, apb_setup;
   logic [2:0] sel;
   logic do_ret, do_push, do_call, do_jump, do_pcl;
   logic [7:0] pcl_val;
   logic [2:0] sp_dec;
   logic [12:0] push_val;
   logic ind_req, ind_self;
   logic [8:0] eff_addr;
   logic [12:0] stack_d [pcs_pkg::STK_DEPTH];
   logic [2:0] push_cnt_q, push_cnt_d, pop_cnt_q, pop_cnt_d;

   // APB handshake and decode
   assign sel = reg_sel(paddr);
   assign apb_wr = psel && penable && pwrite;
   assign apb_setup = psel && !penable;
   assign pready = 1'h1;
   assign pslverr = psel && penable && (sel == pcs_pkg::SEL_NONE);
   assign prdata = prdata_q;

   // Control priority: return, call, interrupt, jump, low-byte write, fetch
   always_comb begin
      do_ret = return_instr;
      do_call = !do_ret && call_instr;
      do_push = !do_ret && (call_instr || int_vector);
      do_jump = !do_ret && !call_instr && !int_vector && jump_instr;
      pcl_val = pcl_wr ? pcl_wdata : pwdata[7:0];
      do_pcl = !do_push && !do_ret && !do_jump &&
               (pcl_wr || (apb_wr && sel == pcs_pkg::SEL_PC_LOW));
      sp_dec = sp_q - 3'h1;
      push_val = pc_q;
   end

   // Program counter and stack pointer next state
   always_comb begin
      pc_d = pc_q;
      sp_d = sp_q;
      if (do_ret) begin
         pc_d = stack_q[sp_dec];
         sp_d = sp_dec;
      end else if (do_call) begin
         pc_d = {latch_q[pcs_pkg::CALL_HI_MSB:pcs_pkg::CALL_HI_LSB], branch_target};
         sp_d = sp_q + 3'h1;
      end else if (int_vector) begin
         pc_d = pcs_pkg::INT_VECTOR;
         sp_d = sp_q + 3'h1;
      end else if (do_jump) begin
         pc_d = {latch_q[pcs_pkg::CALL_HI_MSB:pcs_pkg::CALL_HI_LSB], branch_target};
      end else if (do_pcl) begin
         pc_d = {latch_q, pcl_val};
      end else if (fetch_adv) begin
         pc_d = pc_q + 13'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= pcs_pkg::PC_RST;
         sp_q <= pcs_pkg::SP_RST;
      end else begin
         pc_q <= pc_d;
         sp_q <= sp_d;
      end
   end

   // Return stack storage, one slot per entry, written circularly at the pointer
   for (genvar g = 0; g < pcs_pkg::STK_DEPTH; g++) begin : g_slot
      // Slot takes the counter only when the pointer names it on a push
      always_comb begin
         stack_d[g] = stack_q[g];
         if (do_push && sp_q == 3'(g)) begin
            stack_d[g] = push_val;
         end
      end

      // Slot register; not reset, an early pop reads whatever the slot holds
      always_ff @(posedge pclk) begin
         stack_q[g] <= stack_d[g];
      end
   end

   // Software registers: latch, pointer, bank page bit
   always_comb begin
      latch_d = latch_q;
      pointer_d = pointer_q;
      bank_page_d = bank_page_q;
      if (apb_wr && sel == pcs_pkg::SEL_HIGH_LATCH) latch_d = pwdata[4:0];
      if (apb_wr && sel == pcs_pkg::SEL_POINTER) pointer_d = pwdata[7:0];
      if (apb_wr && sel == pcs_pkg::SEL_BANK_PAGE) bank_page_d = pwdata[0];
   end

   // Read data captured in the setup phase
   always_comb begin
      prdata_d = prdata_q;
      if (apb_setup) begin
         unique case (sel)
            pcs_pkg::SEL_PC_LOW: prdata_d = {24'h000000, pc_q[7:0]};
            pcs_pkg::SEL_HIGH_LATCH: prdata_d = {27'h0000000, latch_q};
            pcs_pkg::SEL_POINTER: prdata_d = {24'h000000, pointer_q};
            pcs_pkg::SEL_BANK_PAGE: prdata_d = {31'h00000000, bank_page_q};
            pcs_pkg::SEL_PC_STATUS: prdata_d = {16'h0000, pc_q[7:0], 3'h0, pc_q[12:8]};
            default: prdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= pcs_pkg::LATCH_RST;
         pointer_q <= pcs_pkg::POINTER_RST;
         bank_page_q <= 1'h0;
         prdata_q <= 32'h00000000;
      end else begin
         latch_q <= latch_d;
         pointer_q <= pointer_d;
         bank_page_q <= bank_page_d;
         prdata_q <= prdata_d;
      end
   end

   // Indirect address formation and data path steering
   always_comb begin
      ind_req = dacc_addr[6:0] == pcs_pkg::IND_PORT_LOC;
      eff_addr = {bank_page_q, pointer_q};
      ind_self = ind_req && (eff_addr[6:0] == pcs_pkg::IND_PORT_LOC);
      mem_addr = ind_req ? eff_addr : dacc_addr;
      mem_we = dacc_valid && dacc_we && !ind_self;
      mem_wdata = dacc_wdata;
      dacc_rdata = ind_self ? 8'h00 : mem_rdata;
   end

   assign pc = pc_q;

   // Checks
   pc_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> pc_q == 13'h0000)
      else $error("counter not zero after reset");
   pcl_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      do_pcl |=> pc_q == {$past(latch_q), $past(pcl_val)})
      else $error("low byte write did not load latch bits");
   call_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      (do_call || do_jump) |=> pc_q[12:11] == $past(latch_q[4:3]) &&
      pc_q[10:0] == $past(branch_target))
      else $error("call or jump target wrong");
   push_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      do_push |=> stack_q[$past(sp_q)] == $past(pc_q) && sp_q == $past(sp_q) + 3'h1)
      else $error("push did not store counter");
   pop_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      do_ret |=> pc_q == $past(stack_q[sp_dec]) && sp_q == $past(sp_dec))
      else $error("pop did not restore counter");
   latch_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      (do_push || do_ret) && !(apb_wr && sel == pcs_pkg::SEL_HIGH_LATCH) |=> $stable(latch_q))
      else $error("latch changed by stack");
   sp_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (do_push && sp_q == 3'h7) |=> sp_q == 3'h0)
      else $error("stack pointer did not wrap");
   fetch_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
      fetch_adv && !do_ret && !do_push && !do_jump && !do_pcl |=> pc_q == $past(pc_q) + 13'h0001)
      else $error("fetch did not advance");
   ind_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      ind_self |-> dacc_rdata == 8'h00 && !mem_we)
      else $error("self indirect access leaked");
   ind_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
      ind_req |-> mem_addr == {bank_page_q, pointer_q})
      else $error("effective address wrong");

   // Tallies of pushes and pops, wrapping like the hidden pointer
   always_comb begin
      push_cnt_d = push_cnt_q;
      pop_cnt_d = pop_cnt_q;
      if (do_push) push_cnt_d = push_cnt_q + 3'h1;
      if (do_ret) pop_cnt_d = pop_cnt_q + 3'h1;
   end

   // Tally registers, cleared with the pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         push_cnt_q <= pcs_pkg::SP_RST;
         pop_cnt_q <= pcs_pkg::SP_RST;
      end else begin
         push_cnt_q <= push_cnt_d;
         pop_cnt_q <= pop_cnt_d;
      end
   end

   // Counter and pointer held at zero while reset is low
   pc_in_reset_a: assert property (@(posedge pclk) !presetn |-> pc_q == 13'h0000 && sp_q == 3'h0)
      else $error("counter or pointer not cleared during reset");
   // Upper bits only move through a control, never on their own
   pc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !do_ret && !do_push && !do_jump && !do_pcl && !fetch_adv |=> $stable(pc_q))
      else $error("counter moved with no control");
   // Low byte read over the bus shows the counter's low byte
   rd_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      apb_setup && sel == pcs_pkg::SEL_PC_LOW |=> prdata == {24'h000000, $past(pc_q[7:0])})
      else $error("low byte read wrong");
   // Software write of the low byte loads all 13 bits at once
   apb_pcl_a: assert property (@(posedge pclk) disable iff (!presetn)
      apb_wr && sel == pcs_pkg::SEL_PC_LOW && !pcl_wr && !do_push && !do_ret && !do_jump
      |=> pc_q == {$past(latch_q), $past(pwdata[7:0])})
      else $error("software low byte write did not load the counter");
   // Interrupt branches to its vector
   int_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
      int_vector && !do_ret && !call_instr |=> pc_q == pcs_pkg::INT_VECTOR)
      else $error("interrupt did not branch to its vector");
   // A jump leaves the stack alone
   jump_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      do_jump |=> sp_q == $past(sp_q))
      else $error("jump moved the stack pointer");
   // Excess pops wrap silently
   pop_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      do_ret && sp_q == 3'h0 |=> sp_q == 3'h7)
      else $error("pop below the first slot did not wrap");
   // Pointer starts from zero after reset
   sp_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> sp_q == 3'h0)
      else $error("stack pointer not zero after reset");
   // Pointer equals pushes minus pops, modulo eight
   sp_track_a: assert property (@(posedge pclk) disable iff (!presetn)
      sp_q == push_cnt_q - pop_cnt_q)
      else $error("stack pointer lost count");
   // Only a bus write moves the latch
   latch_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(apb_wr && sel == pcs_pkg::SEL_HIGH_LATCH) |=> $stable(latch_q))
      else $error("latch changed without a write");
   // Indirect write lands at the pointed location
   ind_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      ind_req && !ind_self && dacc_valid && dacc_we |-> mem_we && mem_addr == eff_addr)
      else $error("indirect write did not reach the pointed location");
   // Direct accesses pass straight through
   direct_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ind_req |-> mem_addr == dacc_addr && dacc_rdata == mem_rdata)
      else $error("direct access was redirected");
   // Self indirect write is dropped
   self_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      ind_self && dacc_valid && dacc_we |-> !mem_we)
      else $error("self indirect write reached memory");
endmodule
`default_nettype wire

// file: verilog/pcs_pkg.sv
// Purpose: Constants for the program counter, return stack and indirect addressing block
// Assumes: APB register map with 32-bit data, one aligned word per register
// Notes: All offsets are byte addresses
package pcs_pkg;
   localparam int PC_W = 13;
   localparam int STK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam int EA_W = 9;
   localparam int TGT_W = 11;
   localparam int LATCH_W = 5;
   // Register offsets
   localparam logic [7:0] OFS_PC_LOW = 8'h00;
   localparam logic [7:0] OFS_HIGH_LATCH = 8'h04;
   localparam logic [7:0] OFS_POINTER = 8'h08;
   localparam logic [7:0] OFS_BANK_PAGE = 8'h0C;
   localparam logic [7:0] OFS_PC_STATUS = 8'h10;
   // Register select codes
   localparam logic [2:0] SEL_NONE = 3'h0;
   localparam logic [2:0] SEL_PC_LOW = 3'h1;
   localparam logic [2:0] SEL_HIGH_LATCH = 3'h2;
   localparam logic [2:0] SEL_POINTER = 3'h3;
   localparam logic [2:0] SEL_BANK_PAGE = 3'h4;
   localparam logic [2:0] SEL_PC_STATUS = 3'h5;
   // Reset values
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [SP_W-1:0] SP_RST = 3'h0;
   localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
   localparam logic [7:0] POINTER_RST = 8'h00;
   // Interrupt vector and indirect port location within a bank
   localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
   localparam logic [6:0] IND_PORT_LOC = 7'h00;
   // Field positions in the high latch
   localparam int CALL_HI_MSB = 4;
   localparam int CALL_HI_LSB = 3;
endpackage

// file: verification/pcs_mem_model.sv
// Purpose: Data memory on the far side of the block's memory port
// Assumes: Reads are combinational and always answered
// Notes: Contents hash the address, so a wrong address reads wrong data unless it differs in exactly bits 8 and 7
`timescale 1ns/1ps
`default_nettype none
module pcs_mem_model (
   input wire logic [8:0] mem_addr, // Address from the block
   input wire logic mem_we, // Write strobe, discarded
   input wire logic [7:0] mem_wdata, // Write data, discarded
   output logic [7:0] mem_rdata // Read data
);
   // Each location reads as its address folded with a fixed pattern
   assign mem_rdata = mem_addr[7:0] ^ {mem_addr[8], 7'h5A};
endmodule
`default_nettype wire

// file: verification/test_pcs_core.sv
// Purpose: Self-checking bench for pcs_core
// Assumes: Core strobes are one-cycle pulses, APB answers without a fixed latency
// Notes: Drivers queue expectations, a monitor compares them at the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_pcs_core;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic pready, pslverr, mem_we, err_c = 1'h0, dacc_valid = 1'h0;
   logic fetch_adv = 1'h0, pcl_wr = 1'h0, call_instr = 1'h0, jump_instr = 1'h0;
   logic int_vector = 1'h0, return_instr = 1'h0, dacc_we = 1'h0;
   logic [7:0] paddr = 8'h00, pcl_wdata = 8'h00, dacc_wdata = 8'h00;
   logic [7:0] dacc_rdata, mem_wdata, mem_rdata;
   logic [31:0] pwdata = 32'h0, prdata, got;
   logic [10:0] branch_target = 11'h000;
   logic [8:0] dacc_addr = 9'h000, mem_addr;
   logic [12:0] epc = 13'h0000, pc;
   logic [12:0] stk [8];
   logic [16:0] rnd = 17'h127DD;
   logic [4:0] lat = 5'h00;
   logic [2:0] sp = 3'h0;
   int n_fail = 0, check_count = 0, kq[$];
   logic [31:0] eq[$];
   pcs_core i_pcs_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .fetch_adv, .pcl_wr, .pcl_wdata, .call_instr, .jump_instr,
      .branch_target, .int_vector, .return_instr, .dacc_valid, .dacc_we, .dacc_addr,
      .dacc_wdata, .dacc_rdata, .mem_addr, .mem_we, .mem_wdata, .mem_rdata, .pc);
   pcs_mem_model i_pcs_mem_model (.mem_addr, .mem_we, .mem_wdata, .mem_rdata);
   // 200 MHz clock
   always #2.5 pclk = ~pclk;
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Queue one expectation for the monitor's next falling edge
   task automatic put(input int k, input logic [31:0] e);
      kq.push_back(k);
      eq.push_back(e);
      @(posedge pclk);
   endtask
   // One core control pulse; 0 fetch, 1 call, 2 jump, 3 return, 4 vector, 5 low byte
   task automatic ctl(input int w, input logic [10:0] t);
      @(posedge pclk);
      {fetch_adv, call_instr, jump_instr} <= {w == 0, w == 1, w == 2};
      {return_instr, int_vector, pcl_wr} <= {w == 3, w == 4, w == 5};
      {branch_target, pcl_wdata} <= {t, t[7:0]};
      @(posedge pclk);
      {fetch_adv, call_instr, jump_instr, return_instr, int_vector, pcl_wr} <= 6'h00;
      case (w)
         0: epc = epc + 13'h0001;
         1, 4: begin
            stk[sp] = epc;
            sp = sp + 3'h1;
            epc = (w == 1) ? {lat[4:3], t} : pcs_pkg::INT_VECTOR;
         end
         2: epc = {lat[4:3], t};
         3: begin
            sp = sp - 3'h1;
            epc = stk[sp];
         end
         default: epc = {lat, t[7:0]};
      endcase
      put(0, {19'h0, epc});
   endtask
   // APB transfer held until pready; reads queue data and error flag
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic ee);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      {err_c, psel, penable} <= {pslverr, 2'h0};
      if (!w) begin
         put(1, e);
         put(5, {31'h0, ee});
      end
   endtask
   // Core data access held for the check cycle
   task automatic dat(input logic we, input logic [8:0] a, input int k, input logic [31:0] e);
      @(posedge pclk);
      {dacc_valid, dacc_we, dacc_addr, dacc_wdata} <= {1'h1, we, a, rnd[7:0]};
      put(k, e);
      dacc_valid <= 1'h0;
   endtask
   // Compare each flagged output with the oldest expectation
   always @(negedge pclk) begin
      if (kq.size() != 0) begin
         case (kq[0])
            0: got = {19'h0, pc};
            1: got = prdata;
            2: got = {24'h0, dacc_rdata};
            3: got = {23'h0, mem_addr};
            4: got = {31'h0, mem_we};
            6: got = {24'h0, mem_wdata};
            default: got = {31'h0, err_c};
         endcase
         check_count++;
         if (got !== eq[0]) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, eq[0]);
         end
         void'(kq.pop_front());
         void'(eq.pop_front());
      end
   end
   // Watchdog well beyond the expected run
   initial begin
      #100000;
      n_fail++;
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      put(0, 32'h0);
      lat = 5'h15;
      apb(1'h1, pcs_pkg::OFS_HIGH_LATCH, 32'hFFFFFFF5, 32'h0, 1'h0);
      apb(1'h0, pcs_pkg::OFS_HIGH_LATCH, 32'h0, 32'h15, 1'h0);
      ctl(5, 11'h0FF);
      apb(1'h0, pcs_pkg::OFS_PC_STATUS, 32'h0, {16'h0, epc[7:0], 3'h0, epc[12:8]}, 1'h0);
      ctl(0, 11'h000);
      lat = 5'h16; // Table crosses a page: software bumps the latch first
      apb(1'h1, pcs_pkg::OFS_HIGH_LATCH, 32'h16, 32'h0, 1'h0);
      ctl(5, 11'h001);
      apb(1'h1, pcs_pkg::OFS_PC_LOW, 32'hA5, 32'h0, 1'h0);
      epc = {lat, 8'hA5};
      put(0, {19'h0, epc});
      apb(1'h0, pcs_pkg::OFS_PC_LOW, 32'h0, {24'h0, epc[7:0]}, 1'h0);
      lat = 5'h1F;
      apb(1'h1, pcs_pkg::OFS_HIGH_LATCH, 32'h1F, 32'h0, 1'h0);
      ctl(5, 11'h0FF);
      ctl(0, 11'h000);
      ctl(2, rnd[10:0]);
      for (int i = 0; i < 9; i++) begin
         rnd = lfsr(rnd);
         ctl(1, rnd[10:0]);
      end
      ctl(4, 11'h000);
      apb(1'h0, pcs_pkg::OFS_HIGH_LATCH, 32'h0, 32'h1F, 1'h0);
      for (int i = 0; i < 10; i++) begin
         ctl(3, 11'h000);
      end
      apb(1'h1, pcs_pkg::OFS_BANK_PAGE, 32'h1, 32'h0, 1'h0);
      apb(1'h1, pcs_pkg::OFS_POINTER, 32'h37, 32'h0, 1'h0);
      dat(1'h0, 9'h100, 3, 32'h137);
      dat(1'h0, 9'h000, 2, {24'h0, 8'h37 ^ 8'hDA});
      dat(1'h1, 9'h000, 4, 32'h1);
      rnd = lfsr(rnd);
      dat(1'h1, 9'h000, 6, {24'h0, rnd[7:0]});
      apb(1'h1, pcs_pkg::OFS_POINTER, 32'h80, 32'h0, 1'h0);
      dat(1'h0, 9'h000, 2, 32'h0);
      dat(1'h1, 9'h000, 4, 32'h0);
      apb(1'h0, 8'h14, 32'h0, 32'h0, 1'h1);
      presetn <= 1'h0;
      epc = 13'h0000;
      put(0, 32'h0);
      put(0, 32'h0);
      presetn <= 1'h1;
      put(0, 32'h0);
      apb(1'h0, pcs_pkg::OFS_PC_STATUS, 32'h0, 32'h0, 1'h0);
      stop_test();
   end
endmodule
`default_nettype wire
